// ---- verilog/enh_led_ctrl.sv ----
// enhanced LED control: pulsing, serial LED stream, port swap, APB registers
//
// How it works
// - Pulsing duty control gates the LEDs only while the pulse enable bit is set.
// - The 8-bit duty code 0..198 gives an on-time of 0.5% up to 99.5%.
// - Each duty step adds half a percent of a 200-step pulse period.
// - With its enable set, the second port's LED pins carry the serial stream.
// - With its enable set, the first port's LED pins carry the serial stream.
// - Frame-rate codes 0..6 give 2500,1000,500,250,200,125 and 40 Hz frames.
// - Frame-rate code all ones sends the basic stream, frames back to back.
// - The select field puts 4, 3, 2 or 1 LEDs of each PHY on the stream.
// - The swap bit exchanges the two ports' LED assignment; it resets to zero.
`timescale 1ns/1ps
`default_nettype none
module enh_led_ctrl
   import enh_led_pkg::*;
#(
   parameter int unsigned CLK_HZ   = CLK_HZ_DEF,
   parameter int unsigned SCLK_DIV = 50,
   parameter int unsigned PWM_DIV  = 250
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic [3:0]  phy0_led,
   input  wire logic [3:0]  phy1_led,
   output var  logic [3:0]  port0_led,
   output var  logic [3:0]  port1_led
);
   // elaboration checks on the divider settings
   if (CLK_HZ / FRAME_HZ[RATE_NUM-1] >= (1 << CNT_W) ||
       CLK_HZ / FRAME_HZ[0] <= 20 * SCLK_DIV || SCLK_DIV < 1 ||
       PWM_DIV < 1 || PWM_DIV >= (1 << CNT_W)) begin : g_bad
      $error("enh_led_ctrl: divider parameters out of range");
   end

   // frame period in cycles for a frame-rate code
   function automatic logic [CNT_W-1:0] frame_cyc(input logic [2:0] rate);
      frame_cyc = CNT_W'(CLK_HZ / FRAME_HZ[(rate == RATE_BASIC) ? 0 : rate]);
   endfunction : frame_cyc

   logic [15:0] settings_reg, settings_next;
   logic [15:0] aux_reg, aux_next;
   logic [31:0] prdata_next;
   logic        pready_next, pslverr_next;
   logic        wr_en;

   wire logic [7:0] duty_raw = settings_reg[DUTY_LSB +: 8];
   wire logic       p1_en    = settings_reg[P1_EN_BIT];
   wire logic       p0_en    = settings_reg[P0_EN_BIT];
   wire logic [2:0] rate     = settings_reg[RATE_LSB +: 3];
   wire logic [1:0] sel      = settings_reg[SEL_LSB +: 2];
   wire logic       swap     = settings_reg[SWAP_BIT];
   wire logic       pulse_en = aux_reg[PULSE_EN_BIT];
   wire logic       basic    = (rate == RATE_BASIC);

   logic         frame_tick, bit_tick, pwm_tick;
   shift_state_t sh_state_reg, sh_state_next;
   logic [3:0]   bit_idx_reg, bit_idx_next;
   logic [3:0]   bits_left_reg, bits_left_next;
   logic [7:0]   pwm_step_reg, pwm_step_next;
   logic [7:0]   duty_eff;
   logic         pwm_on, gate;
   logic [3:0]   led_a, led_b;
   logic [2:0]   n_led;
   logic         sdata;
   logic [3:0]   ser_pins;
   logic [3:0]   port0_next, port1_next;

   // dividers for frame rate, serial bit clock and pulse steps
   tick_gen #(.W(CNT_W)) u_frame (
      .pclk    (pclk),
      .presetn (presetn),
      .period  (frame_cyc(rate)),
      .tick    (frame_tick)
   );
   tick_gen #(.W(CNT_W)) u_bit (
      .pclk    (pclk),
      .presetn (presetn),
      .period  (CNT_W'(SCLK_DIV)),
      .tick    (bit_tick)
   );
   tick_gen #(.W(CNT_W)) u_pwm (
      .pclk    (pclk),
      .presetn (presetn),
      .period  (CNT_W'(PWM_DIV)),
      .tick    (pwm_tick)
   );

   // apb slave: answer in the first access cycle, writes at that edge
   always_comb begin
      wr_en         = psel && penable && pready && pwrite && !pslverr;
      settings_next = settings_reg;
      aux_next      = aux_reg;
      if (wr_en && paddr == SETTINGS_ADDR) begin
         settings_next = pwdata[15:0];
      end
      if (wr_en && paddr == AUX_ADDR) begin
         aux_next = {15'h0000, pwdata[PULSE_EN_BIT]};
      end
      pready_next  = psel && !penable;
      pslverr_next = 1'b0;
      prdata_next  = prdata;
      if (psel && !penable) begin
         unique case (paddr)
            SETTINGS_ADDR: prdata_next = {16'h0000, settings_reg};
            AUX_ADDR:      prdata_next = {16'h0000, aux_reg};
            STATUS_ADDR:   prdata_next = {16'h0000, 2'b00, pwm_on,
                                          sh_state_reg != SH_IDLE,
                                          bits_left_reg, duty_eff};
            default: begin
               prdata_next  = 32'h0000_0000;
               pslverr_next = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settings_reg <= SETTINGS_RESET;
         aux_reg      <= AUX_RESET;
         prdata       <= 32'h0000_0000;
         pready       <= 1'b0;
         pslverr      <= 1'b0;
      end else begin
         settings_reg <= settings_next;
         aux_reg      <= aux_next;
         prdata       <= prdata_next;
         pready       <= pready_next;
         pslverr      <= pslverr_next;
      end
   end

   // pulse generator: 200 steps, on for duty+1 steps
   always_comb begin
      duty_eff = (duty_raw > DUTY_MAX) ? DUTY_MAX : duty_raw;
      pwm_on   = (pwm_step_reg <= duty_eff);
      gate     = pulse_en ? pwm_on : 1'b1;
      pwm_step_next = pwm_step_reg;
      if (pwm_tick) begin
         pwm_step_next = (pwm_step_reg >= PWM_LAST) ? 8'h00
                                                    : pwm_step_reg + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_step_reg <= 8'h00;
      end else begin
         pwm_step_reg <= pwm_step_next;
      end
   end

   // serial shifter: led_a's LEDs then led_b's, high index first; swap picks which PHY is led_a
   always_comb begin
      led_a = (swap ? phy1_led : phy0_led) & {4{gate}};
      led_b = (swap ? phy0_led : phy1_led) & {4{gate}};
      n_led = led_count(sel);
      if (bit_idx_reg < 4'(n_led)) begin
         sdata = led_a[2'(4'(n_led) - 4'd1 - bit_idx_reg)];
      end else begin
         sdata = led_b[2'(4'(2 * n_led) - 4'd1 - bit_idx_reg)];
      end
      sh_state_next  = sh_state_reg;
      bit_idx_next   = bit_idx_reg;
      bits_left_next = bits_left_reg;
      unique case (sh_state_reg)
         SH_IDLE: begin
            if (frame_tick || basic) begin
               sh_state_next  = SH_LOW;
               bit_idx_next   = 4'h0;
               bits_left_next = 4'(2 * n_led);
            end
         end
         SH_LOW: begin
            if (bit_tick) begin
               sh_state_next = SH_HIGH;
            end
         end
         SH_HIGH: begin
            if (bit_tick) begin
               bit_idx_next   = bit_idx_reg + 4'h1;
               bits_left_next = bits_left_reg - 4'h1;
               sh_state_next  = (bits_left_reg == 4'h1) ? SH_LATCH : SH_LOW;
            end
         end
         SH_LATCH: begin
            if (bit_tick) begin
               sh_state_next = SH_IDLE;
            end
         end
      endcase
      ser_pins = 4'h0;
      ser_pins[PIN_SCLK]  = (sh_state_reg == SH_HIGH);
      ser_pins[PIN_SDATA] = (sh_state_reg == SH_LOW ||
                             sh_state_reg == SH_HIGH) && sdata;
      ser_pins[PIN_LATCH] = (sh_state_reg == SH_LATCH);
      port0_next = p0_en ? ser_pins : led_a;
      port1_next = p1_en ? ser_pins : led_b;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_state_reg  <= SH_IDLE;
         bit_idx_reg   <= 4'h0;
         bits_left_reg <= 4'h0;
         port0_led     <= 4'h0;
         port1_led     <= 4'h0;
      end else begin
         sh_state_reg  <= sh_state_next;
         bit_idx_reg   <= bit_idx_next;
         bits_left_reg <= bits_left_next;
         port0_led     <= port0_next;
         port1_led     <= port1_next;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_PULSE_OFF: assert property (
      !pulse_en && !p0_en && !swap |=> port0_led == $past(phy0_led))
      else $error("led not steady with pulsing off");
   AST_DUTY_ON: assert property (
      pulse_en && !p0_en && !swap && pwm_step_reg == 8'h00 && phy0_led[0]
      |=> port0_led[0])
      else $error("code zero gave no on step");
   AST_DUTY_STEP: assert property (
      pulse_en && pwm_step_reg == duty_eff + 8'h01 |-> !gate)
      else $error("led on past duty step");
   AST_DUTY_CLAMP: assert property (
      duty_raw > DUTY_MAX
      |-> duty_eff == DUTY_MAX && (pwm_on || pwm_step_reg == PWM_LAST))
      else $error("reserved duty code not clamped");
   AST_P1_SERIAL: assert property (
      p1_en |=> port1_led[3] == 1'b0 &&
                port1_led[PIN_SCLK] == $past(sh_state_reg == SH_HIGH))
      else $error("port 1 not on serial stream");
   AST_P0_SERIAL: assert property (
      p0_en |=> port0_led[PIN_LATCH] == $past(sh_state_reg == SH_LATCH))
      else $error("port 0 not on serial stream");
   AST_FRAME_START: assert property (
      sh_state_reg == SH_IDLE && frame_tick |=> sh_state_reg == SH_LOW)
      else $error("frame tick did not start a frame");
   AST_BASIC: assert property (
      basic && sh_state_reg == SH_LATCH && bit_tick
      |=> sh_state_reg == SH_IDLE
          ##1 (sh_state_reg == SH_LOW || !$past(basic)))
      else $error("basic stream paused between frames");
   AST_SEL_COUNT: assert property (
      sh_state_reg == SH_IDLE && sh_state_next == SH_LOW
      |=> bits_left_reg == 4'(2 * led_count($past(sel))))
      else $error("wrong led count on stream");
   AST_SWAP: assert property (
      swap && !p0_en && !pulse_en |=> port0_led == $past(phy1_led))
      else $error("ports not swapped");
endmodule : enh_led_ctrl
`default_nettype wire

// ---- verilog/enh_led_pkg.sv ----
// constants and types shared by the enhanced LED control block
package enh_led_pkg;
   // register indices; byte address is four times the index
   localparam int unsigned SETTINGS_IDX = 'h19;
   localparam int unsigned AUX_IDX      = 'h1A;
   localparam int unsigned STATUS_IDX   = 'h1B;
   localparam logic [11:0] SETTINGS_ADDR = 12'(4 * SETTINGS_IDX);
   localparam logic [11:0] AUX_ADDR      = 12'(4 * AUX_IDX);
   localparam logic [11:0] STATUS_ADDR   = 12'(4 * STATUS_IDX);
   localparam logic [15:0] SETTINGS_RESET = 16'h0000;
   localparam logic [15:0] AUX_RESET      = 16'h0000;
   // settings register field positions, and the aux pulse enable bit
   localparam int unsigned DUTY_LSB  = 8;
   localparam int unsigned P1_EN_BIT = 7;
   localparam int unsigned P0_EN_BIT = 6;
   localparam int unsigned RATE_LSB  = 3;
   localparam int unsigned SEL_LSB   = 1;
   localparam int unsigned SWAP_BIT  = 0;
   localparam int unsigned PULSE_EN_BIT = 0;
   // duty and frame codes, clock rate and counter width
   localparam logic [7:0] DUTY_MAX   = 8'hC6;
   localparam logic [7:0] PWM_LAST   = 8'hC7;
   localparam logic [2:0] RATE_BASIC = 3'h7;
   localparam int unsigned RATE_NUM  = 7;
   localparam int unsigned FRAME_HZ [RATE_NUM] =
      '{2500, 1000, 500, 250, 200, 125, 40};
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned CLK_HZ_DEF = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 24;
   // serial pin roles on a port in serial mode
   localparam int unsigned PIN_SCLK  = 0;
   localparam int unsigned PIN_SDATA = 1;
   localparam int unsigned PIN_LATCH = 2;

   typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH, SH_LATCH} shift_state_t;

   // number of LEDs of each PHY that go on the stream
   function automatic logic [2:0] led_count(input logic [1:0] sel);
      led_count = 3'(4) - 3'(sel);
   endfunction : led_count
endpackage : enh_led_pkg

// ---- verilog/tick_gen.sv ----
// programmable divider giving a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
   parameter int unsigned W = 24
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] period,
   output var  logic         tick
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic         tick_next;

   // count down to zero, then reload period minus one
   always_comb begin
      tick_next = (cnt_reg == '0);
      if (cnt_reg == '0 || cnt_reg >= period) begin
         cnt_next = (period == '0) ? '0 : period - W'(1);
      end else begin
         cnt_next = cnt_reg - W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick    <= tick_next;
      end
   end
endmodule : tick_gen
`default_nettype wire

// ---- testbench/led_shift_rx.sv ----
// serial LED shift register model fed by one port's serial pins
`timescale 1ns/1ps
`default_nettype none
module led_shift_rx (
   input  wire logic       sclk,
   input  wire logic       sdata,
   input  wire logic       latch,
   output var  logic [7:0] word_q,
   output var  int         nbits_q,
   output var  int         frames
);
   logic [7:0] sh;
   int         bits;
   // nothing shifted and nothing shown before the first frame
   initial begin
      sh = 8'h00;
      bits = 0;
      {word_q, nbits_q, frames} = '0;
   end
   // data enters on each rising serial clock, first bit ends up highest
   always @(posedge sclk) begin
      sh = {sh[6:0], sdata};
      bits = bits + 1;
   end
   // latch hands the shifted frame to the LED drivers
   always @(posedge latch) begin
      word_q <= sh;
      nbits_q <= bits;
      bits = 0;
      frames <= frames + 1;
   end
endmodule : led_shift_rx
`default_nettype wire

// ---- testbench/enh_led_ctrl_tb.sv ----
// self-checking bench for the enhanced LED control block
`timescale 1ns/1ps
`default_nettype none
module enh_led_ctrl_tb;
   import enh_led_pkg::*;
   localparam int unsigned SIM_HZ = 400000;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  phy0_led, phy1_led, port0_led, port1_led;
   logic [7:0]  word_q;
   int          nbits_q, frames, error_cnt, n_tests, cyc, on, n, m, e;

   enh_led_ctrl #(.CLK_HZ(SIM_HZ), .SCLK_DIV(2), .PWM_DIV(2)) u_enh_led_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .phy0_led(phy0_led),
      .phy1_led(phy1_led), .port0_led(port0_led), .port1_led(port1_led));
   led_shift_rx u_led_shift_rx (.sclk(port0_led[0]), .sdata(port0_led[1]),
      .latch(port0_led[2]), .word_q(word_q), .nbits_q(nbits_q),
      .frames(frames));

   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // counts, verdict and end of run
   task automatic stop_test();
      $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   // one APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      // pready, prdata and pslverr are read as sampled at this edge
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // wait for the next latched frame, cyc gets the cycles waited
   task automatic wait_frame();
      int f;
      f = frames;
      cyc = 0;
      while (frames == f && cyc < 12000) begin
         @(negedge pclk);
         cyc++;
      end
      if (cyc >= 12000) begin
         error_cnt++;
         stop_test();
      end
   endtask : wait_frame
   // on-cycles of an LED over one 400-cycle pulse period
   task automatic duty(input logic [7:0] d, input int exp);
      apb(1'b1, SETTINGS_ADDR, {16'h0000, d, 8'h00});
      repeat (400) @(negedge pclk);
      on = 0;
      repeat (400) begin
         @(negedge pclk);
         on += int'(port0_led[0]);
      end
      chk(on, exp);
   endtask : duty

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // main sequence
   initial begin
      {presetn, psel, penable, pwrite} = 4'h0;
      {paddr, pwdata} = '0;
      phy0_led = 4'hA;
      phy1_led = 4'h6;
      {error_cnt, n_tests} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, stored width, unmapped place
      apb(1'b0, SETTINGS_ADDR, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h0);
      apb(1'b0, AUX_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, SETTINGS_ADDR, 32'hFFFFFFFF);
      apb(1'b0, SETTINGS_ADDR, 32'h0);
      chk(rd, 32'h0000FFFF);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk(rd[7:0], DUTY_MAX);
      apb(1'b0, 12'h070, 32'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0);
      $display("registers done");
      // normal pins, swap, one port serial at a time
      apb(1'b1, SETTINGS_ADDR, 32'h0);
      repeat (4) @(negedge pclk);
      chk({port1_led, port0_led}, 8'h6A);
      apb(1'b1, SETTINGS_ADDR, 32'h1);
      repeat (4) @(negedge pclk);
      chk({port1_led, port0_led}, 8'hA6);
      apb(1'b1, SETTINGS_ADDR, 32'h80);
      repeat (4) @(negedge pclk);
      chk({port1_led[3], port0_led}, 5'h0A);
      apb(1'b1, SETTINGS_ADDR, 32'h40);
      repeat (4) @(negedge pclk);
      chk({port1_led, port0_led[3]}, 5'h0C);
      $display("pins done");
      // pulsing duty codes
      @(posedge pclk);
      phy0_led <= 4'hF;
      apb(1'b1, AUX_ADDR, 32'h1);
      duty(8'h00, 2);
      duty(8'h64, 202);
      duty(DUTY_MAX, 398);
      duty(8'hFF, 398);
      apb(1'b1, AUX_ADDR, 32'h0);
      duty(8'h00, 400);
      $display("pulsing done");
      // basic stream: every select code, with and without swap
      @(posedge pclk);
      phy0_led <= 4'hA;
      for (int s = 0; s < 8; s++) begin
         n = 4 - (s % 4);
         m = (1 << n) - 1;
         e = s < 4 ? ((10 & m) << n) | (6 & m) : ((6 & m) << n) | (10 & m);
         apb(1'b1, SETTINGS_ADDR, 32'(32'hF8 | ((s % 4) << 1) | (s / 4)));
         repeat (3) wait_frame();
         chk(nbits_q, 2 * n);
         chk(32'(word_q) & ((1 << 2 * n) - 1), e);
         chk(cyc < SIM_HZ / 5000, 1);
      end
      $display("select done");
      // frame rate codes
      for (int c = 0; c < 7; c++) begin
         apb(1'b1, SETTINGS_ADDR, 32'(32'hC0 | (c << 3)));
         repeat (3) wait_frame();
         chk(cyc, SIM_HZ / FRAME_HZ[c]);
      end
      $display("rates done");
      stop_test();
   end
endmodule : enh_led_ctrl_tb
`default_nettype wire
